// >>> src/mtbd_cfg.svh
// constants for the midi transport and bulk dump block
`ifndef MTBD_CFG_SVH
`define MTBD_CFG_SVH
`define MTBD_RT_START 8'hFA
`define MTBD_RT_CONT 8'hFB
`define MTBD_RT_STOP 8'hFC
`define MTBD_RT_MIN 8'hF8
`define MTBD_SYSEX_BEGIN 8'hF0
`define MTBD_SYSEX_END 8'hF7
`define MTBD_STATUS_BIT 7
`define MTBD_PAT_COUNT 128
`define MTBD_SONG_COUNT 10
`define MTBD_WORDS_PER_ITEM 16
`define MTBD_SYS_WORDS 16
`define MTBD_REGION_PAT 2'h0
`define MTBD_REGION_SONG 2'h1
`define MTBD_REGION_SYS 2'h2
`endif

// >>> src/mtbd_pkg.sv
// types for the midi transport and bulk dump block
package mtbd_pkg;
  typedef enum logic [1:0] {
    MTBD_CTL_ON = 2'h0,
    MTBD_CTL_OUT = 2'h1,
    MTBD_CTL_IN = 2'h2,
    MTBD_CTL_OFF = 2'h3
  } mtbd_ctl_t;
  typedef enum logic [1:0] {
    MTBD_DUMP_PAT = 2'h0,
    MTBD_DUMP_SONG = 2'h1,
    MTBD_DUMP_ALL = 2'h2
  } mtbd_dump_t;
  typedef enum logic [3:0] {
    MTBD_ST_IDLE = 4'h1,
    MTBD_ST_ARMED = 4'h2,
    MTBD_ST_READ = 4'h4,
    MTBD_ST_SEND = 4'h8
  } mtbd_state_t;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } mtbd_byte_t;
endpackage : mtbd_pkg

// >>> src/mtbd_store.sv
// dump storage memory with registered read data
`timescale 1ns/10ps
module mtbd_store #(
  parameter int AW = 12
) (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [0:(1<<AW)-1];
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule : mtbd_store

// >>> src/mtbd_top.sv
// midi transport control gate and bulk dump engine
// How it works
// - allowed FA input rewinds song position and starts playback
// - allowed FB input resumes playback from present position
// - allowed FC input halts playback
// - setting on both sends and obeys transport messages
// - setting out sends transport messages, ignores incoming ones
// - setting in obeys incoming messages, never sends them
// - setting off neither sends nor obeys transport messages
// - pattern dump sends only the 128-pattern store
// - song dump sends only the 10-song store
// - all dump sends patterns, songs and system settings
// - first trigger arms, second starts sending; cancel aborts
// - incoming dump accepted automatically, stored in arrival order from the pattern region up
// - received dump overwrites existing stored data
// - control-change setting picks limited or full parameter set
`timescale 1ns/10ps
`include "mtbd_cfg.svh"
module mtbd_top
  import mtbd_pkg::*;
#(
  parameter int ITEM_WORDS = `MTBD_WORDS_PER_ITEM,
  parameter int AW = 12
) (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic RESET_I,
  // settings
  input wire logic [1:0] LINK_SETUP_SELECTOR_I,
  input wire logic [1:0] DUMP_TYPE_I,
  input wire logic CC_FULL_SET_I,
  // user controls
  input wire logic DUMP_TRIGGER_CONTROL_I,
  input wire logic CANCEL_I,
  input wire logic PANEL_START_I,
  input wire logic PANEL_CONT_I,
  input wire logic PANEL_STOP_I,
  // midi byte streams
  input wire logic RX_VALID_I,
  input wire logic [7:0] RX_DATA_I,
  input wire logic TX_READY_I,
  output logic TX_VALID_O,
  output logic [7:0] TX_DATA_O,
  // passed traffic
  output logic PASS_VALID_O,
  output logic [7:0] PASS_DATA_O,
  // transport and status
  output logic PLAYING_O,
  output logic REWIND_O,
  output logic DUMP_ARMED_O,
  output logic DUMP_BUSY_O,
  output logic LOADING_O,
  output logic CC_FULL_SET_O
);
  localparam int PAT_WORDS = `MTBD_PAT_COUNT * ITEM_WORDS;
  localparam int SONG_WORDS = `MTBD_SONG_COUNT * ITEM_WORDS;
  localparam int ALL_WORDS = PAT_WORDS + SONG_WORDS + `MTBD_SYS_WORDS;

  mtbd_state_t state;
  mtbd_state_t next_state;
  mtbd_ctl_t ctl;
  mtbd_byte_t rx;
  logic [AW-1:0] rd_ptr;
  logic [AW-1:0] rd_end;
  logic [AW-1:0] wr_ptr;
  logic [7:0] rdata;
  logic loading;
  logic trig_q;

  function automatic logic [AW-1:0] region_base(input logic [1:0] r);
    logic [AW-1:0] b;
    b = '0;
    unique case (r)
      `MTBD_REGION_PAT: b = '0;
      `MTBD_REGION_SONG: b = AW'(PAT_WORDS);
      default: b = AW'(PAT_WORDS + SONG_WORDS);
    endcase
    return b;
  endfunction : region_base

  function automatic logic is_rt(input logic [7:0] d);
    return (d == `MTBD_RT_START) || (d == `MTBD_RT_CONT) || (d == `MTBD_RT_STOP);
  endfunction : is_rt

  assign ctl = mtbd_ctl_t'(LINK_SETUP_SELECTOR_I);
  assign rx = '{valid: RX_VALID_I, data: RX_DATA_I};

  // receive and send permissions
  wire rx_allowed = (ctl == MTBD_CTL_ON) || (ctl == MTBD_CTL_IN);
  wire tx_allowed = (ctl == MTBD_CTL_ON) || (ctl == MTBD_CTL_OUT);
  wire rx_rt = rx.valid && is_rt(rx.data);
  wire rx_start = rx_rt && rx_allowed && (rx.data == `MTBD_RT_START);
  wire rx_cont = rx_rt && rx_allowed && (rx.data == `MTBD_RT_CONT);
  wire rx_stop = rx_rt && rx_allowed && (rx.data == `MTBD_RT_STOP);
  wire rx_other_rt = rx.valid && (rx.data >= `MTBD_RT_MIN) && !is_rt(rx.data);
  wire rx_plain = rx.valid && !rx_rt && !rx_other_rt;

  // panel transport, with its message
  wire pnl_any = PANEL_START_I || PANEL_CONT_I || PANEL_STOP_I;
  wire do_start = rx_start || PANEL_START_I;
  wire do_cont = rx_cont || PANEL_CONT_I;
  wire do_stop = rx_stop || PANEL_STOP_I;
  wire [7:0] pnl_msg = PANEL_STOP_I ? `MTBD_RT_STOP :
                       PANEL_START_I ? `MTBD_RT_START : `MTBD_RT_CONT;

  // incoming dump framing
  wire rx_sysex_begin = rx_plain && (rx.data == `MTBD_SYSEX_BEGIN);
  wire rx_sysex_end = rx_plain && (rx.data == `MTBD_SYSEX_END);
  wire rx_load_byte = loading && rx_plain && !rx.data[`MTBD_STATUS_BIT];
  wire store_we = rx_load_byte;

  // dump trigger edge and region
  wire trig = DUMP_TRIGGER_CONTROL_I && !trig_q;
  wire [AW-1:0] dump_base = (DUMP_TYPE_I == MTBD_DUMP_SONG) ?
                            region_base(`MTBD_REGION_SONG) : '0;
  wire [AW-1:0] dump_end = (DUMP_TYPE_I == MTBD_DUMP_PAT) ? AW'(PAT_WORDS) :
                           (DUMP_TYPE_I == MTBD_DUMP_SONG) ?
                           AW'(PAT_WORDS + SONG_WORDS) : AW'(ALL_WORDS);
  wire tx_free = !TX_VALID_O || TX_READY_I;
  wire send_rt = tx_allowed && pnl_any && tx_free;
  wire send_dump = (state == MTBD_ST_SEND) && tx_free && !send_rt;
  wire last_word = (rd_ptr == rd_end - AW'(1));

  always_comb begin
    next_state = state;
    unique case (state)
      MTBD_ST_IDLE: if (trig) next_state = MTBD_ST_ARMED;
      MTBD_ST_ARMED: begin
        if (CANCEL_I) next_state = MTBD_ST_IDLE;
        else if (trig) next_state = MTBD_ST_READ;
      end
      MTBD_ST_READ: next_state = CANCEL_I ? MTBD_ST_IDLE : MTBD_ST_SEND;
      MTBD_ST_SEND: begin
        if (CANCEL_I) next_state = MTBD_ST_IDLE;
        else if (send_dump && last_word) next_state = MTBD_ST_IDLE;
        else if (send_dump) next_state = MTBD_ST_READ;
      end
      default: next_state = MTBD_ST_IDLE;
    endcase
  end

  mtbd_store #(.AW(AW)) u_store (
    .clk_i(MCLK_I),
    .we_i(store_we),
    .waddr_i(wr_ptr),
    .wdata_i(rx.data),
    .raddr_i(rd_ptr),
    .rdata_o(rdata)
  );

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      state <= MTBD_ST_IDLE;
      trig_q <= 1'b0;
      rd_ptr <= '0;
      rd_end <= '0;
    end else begin
      state <= next_state;
      trig_q <= DUMP_TRIGGER_CONTROL_I;
      if (state == MTBD_ST_ARMED && trig) begin
        rd_ptr <= dump_base;
        rd_end <= dump_end;
      end else if (send_dump) begin
        rd_ptr <= rd_ptr + AW'(1);
      end
    end
  end

  // incoming dump: starts by itself, fills from the pattern region up
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      loading <= 1'b0;
      wr_ptr <= '0;
    end else if (rx_sysex_begin && state == MTBD_ST_IDLE) begin
      loading <= 1'b1;
      wr_ptr <= region_base(`MTBD_REGION_PAT);
    end else if (rx_sysex_end) begin
      loading <= 1'b0;
    end else if (store_we) begin
      wr_ptr <= (wr_ptr == AW'(ALL_WORDS - 1)) ? wr_ptr : wr_ptr + AW'(1);
    end
  end

  // transport state
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      PLAYING_O <= 1'b0;
      REWIND_O <= 1'b0;
    end else begin
      REWIND_O <= do_start;
      if (do_stop) PLAYING_O <= 1'b0;
      else if (do_start || do_cont) PLAYING_O <= 1'b1;
    end
  end

  // output streams
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      TX_VALID_O <= 1'b0;
      TX_DATA_O <= 8'h00;
      PASS_VALID_O <= 1'b0;
      PASS_DATA_O <= 8'h00;
      DUMP_ARMED_O <= 1'b0;
      DUMP_BUSY_O <= 1'b0;
      LOADING_O <= 1'b0;
      CC_FULL_SET_O <= 1'b0;
    end else begin
      if (send_rt) begin
        TX_VALID_O <= 1'b1;
        TX_DATA_O <= pnl_msg;
      end else if (send_dump) begin
        TX_VALID_O <= 1'b1;
        TX_DATA_O <= rdata;
      end else if (TX_READY_I) begin
        TX_VALID_O <= 1'b0;
      end
      PASS_VALID_O <= rx.valid && !rx_rt;
      PASS_DATA_O <= rx.data;
      DUMP_ARMED_O <= (next_state == MTBD_ST_ARMED);
      DUMP_BUSY_O <= (next_state == MTBD_ST_READ) || (next_state == MTBD_ST_SEND);
      LOADING_O <= loading;
      CC_FULL_SET_O <= CC_FULL_SET_I;
    end
  end
endmodule : mtbd_top

// >>> verification/mtbd_props.sv
// assertions on the transport gate and dump engine ports
`timescale 1ns/10ps
module mtbd_props (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic RESET_I,
  // controls
  input wire logic [1:0] LINK_SETUP_SELECTOR_I,
  input wire logic DUMP_TRIGGER_CONTROL_I,
  input wire logic CANCEL_I,
  input wire logic PANEL_START_I,
  input wire logic PANEL_CONT_I,
  input wire logic PANEL_STOP_I,
  // streams and status
  input wire logic RX_VALID_I,
  input wire logic [7:0] RX_DATA_I,
  input wire logic TX_VALID_O,
  input wire logic [7:0] TX_DATA_O,
  input wire logic PASS_VALID_O,
  input wire logic [7:0] PASS_DATA_O,
  input wire logic PLAYING_O,
  input wire logic REWIND_O,
  input wire logic DUMP_ARMED_O,
  input wire logic DUMP_BUSY_O,
  input wire logic LOADING_O
);
  default clocking dc @(posedge MCLK_I);
  endclocking
  default disable iff (RESET_I);
  wire obey = !LINK_SETUP_SELECTOR_I[0];
  wire emit = !LINK_SETUP_SELECTOR_I[1];
  wire idle = !DUMP_ARMED_O && !DUMP_BUSY_O;
  wire pan = PANEL_START_I || PANEL_CONT_I || PANEL_STOP_I;
  wire rt = RX_VALID_I && RX_DATA_I inside {8'hFA, 8'hFB, 8'hFC};
  a_start_rewind: assert property (
    rt && RX_DATA_I == 8'hFA && obey && !PANEL_STOP_I |=> REWIND_O && PLAYING_O)
    else $error("start not obeyed");
  a_stop_halt: assert property (rt && RX_DATA_I == 8'hFC && obey |=> !PLAYING_O)
    else $error("stop not obeyed");
  a_rx_ignore: assert property (rt && !obey && !pan |=> $stable(PLAYING_O) && !REWIND_O)
    else $error("blocked message obeyed");
  a_tx_start: assert property (
    PANEL_START_I && !PANEL_STOP_I && emit && !TX_VALID_O && idle
    |=> TX_VALID_O && TX_DATA_O == 8'hFA)
    else $error("start not sent");
  a_pass_other: assert property (
    RX_VALID_I && !rt |=> PASS_VALID_O && PASS_DATA_O == $past(RX_DATA_I))
    else $error("byte not passed");
  a_arm_first: assert property (
    $rose(DUMP_TRIGGER_CONTROL_I) && idle && !CANCEL_I |=> DUMP_ARMED_O && !DUMP_BUSY_O)
    else $error("dump not armed");
  a_cancel_dump: assert property (CANCEL_I && !idle |=> idle)
    else $error("dump not cancelled");
  a_load_start: assert property (
    RX_VALID_I && RX_DATA_I == 8'hF0 && idle |-> ##[1:2] LOADING_O)
    else $error("load not started");
  a_silent_panel: assert property (
    pan && !emit && !TX_VALID_O && idle |=> !TX_VALID_O)
    else $error("transport message sent");
endmodule : mtbd_props
bind mtbd_top mtbd_props u_props (.*);

// >>> verification/mtbd_far.sv
// far-side sequencer model: byte source and stalling recorder
`timescale 1ns/10ps
module mtbd_far (
  input wire logic clk_i,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  input wire logic slow_i,
  output logic tx_ready_o = 1'h1,
  output logic rx_valid_o = 1'h0,
  output logic [7:0] rx_data_o = 8'h00
);
  logic [7:0] got[$];
  logic ph = 1'h0;
  // recorder always listening before any dump starts
  always @(posedge clk_i) begin
    if (tx_valid_i && tx_ready_o)
      got.push_back(tx_data_i);
    ph <= !ph;
    tx_ready_o <= !slow_i || ph;
  end
  task automatic send(input logic [7:0] b);
    @(posedge clk_i);
    rx_valid_o <= 1'h1;
    rx_data_o <= b;
    @(posedge clk_i);
    rx_valid_o <= 1'h0;
    rx_data_o <= ~b;
    #1;
  endtask : send
endmodule : mtbd_far

// >>> verification/testbench.sv
// self-checking bench for the transport gate and bulk dump
`timescale 1ns/10ps
module testbench;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [1:0] sel = 2'h0;
  logic [1:0] dtype = 2'h0;
  logic cc = 1'h0;
  logic trig = 1'h0;
  logic cancel = 1'h0;
  logic [2:0] pan = 3'h0;
  logic slow = 1'h0;
  logic rxv, txr, txv, pv, play, rew, armed, busy, loading, ccf;
  logic [7:0] rxd, txd, pd;
  int fails = 0;
  int checked = 0;
  initial begin
    forever #12.5 clk = ~clk;
  end
  mtbd_top u_dut (.MCLK_I(clk), .RESET_I(rst), .LINK_SETUP_SELECTOR_I(sel),
    .DUMP_TYPE_I(dtype), .CC_FULL_SET_I(cc), .DUMP_TRIGGER_CONTROL_I(trig),
    .CANCEL_I(cancel), .PANEL_START_I(pan[0]), .PANEL_CONT_I(pan[1]),
    .PANEL_STOP_I(pan[2]), .RX_VALID_I(rxv), .RX_DATA_I(rxd), .TX_READY_I(txr),
    .TX_VALID_O(txv), .TX_DATA_O(txd), .PASS_VALID_O(pv), .PASS_DATA_O(pd),
    .PLAYING_O(play), .REWIND_O(rew), .DUMP_ARMED_O(armed), .DUMP_BUSY_O(busy),
    .LOADING_O(loading), .CC_FULL_SET_O(ccf));
  mtbd_far u_far (.clk_i(clk), .tx_valid_i(txv), .tx_data_i(txd), .slow_i(slow),
    .tx_ready_o(txr), .rx_valid_o(rxv), .rx_data_o(rxd));
  task automatic chk(input string n, input logic [11:0] seen, input logic [11:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic rxq(input logic [7:0] b, input logic pl, input logic rw);
    u_far.send(b);
    chk("playing", play, pl);
    chk("rewind", rew, rw);
    chk("pass", pv, 1'h0);
  endtask : rxq
  task automatic pulse(input logic [2:0] p, input logic [7:0] b, input logic on);
    @(posedge clk);
    pan <= p;
    @(posedge clk);
    pan <= 3'h0;
    #1;
    chk("tx valid", txv, on);
    if (on)
      chk("tx data", txd, b);
  endtask : pulse
  task automatic t_setting(input logic [1:0] s);
    logic ob;
    logic em;
    ob = !s[0];
    em = !s[1];
    @(posedge clk);
    sel <= s;
    rxq(8'hFA, ob, ob);
    rxq(8'hFC, 1'h0, 1'h0);
    rxq(8'hFB, ob, 1'h0);
    rxq(8'hFC, 1'h0, 1'h0);
    u_far.send(8'hF8);
    chk("pass", {pv, pd}, 9'h1F8);
    pulse(3'h1, 8'hFA, em);
    chk("panel play", play, 1'h1);
    pulse(3'h4, 8'hFC, em);
    pulse(3'h2, 8'hFB, em);
    pulse(3'h4, 8'hFC, em);
  endtask : t_setting
  task automatic trg;
    @(posedge clk);
    trig <= 1'h1;
    @(posedge clk);
    trig <= 1'h0;
    tick(1);
  endtask : trg
  task automatic cnl;
    @(posedge clk);
    cancel <= 1'h1;
    @(posedge clk);
    cancel <= 1'h0;
    tick(1);
    chk("cancel", {armed, busy}, 2'h0);
  endtask : cnl
  task automatic t_cancel;
    trg;
    chk("armed", {armed, busy}, 2'h2);
    cnl;
    trg;
    trg;
    chk("busy", busy, 1'h1);
    cnl;
  endtask : t_cancel
  task automatic t_cc;
    chk("cc", ccf, 1'h0);
    @(posedge clk);
    cc <= 1'h1;
    tick(2);
    chk("cc", ccf, 1'h1);
  endtask : t_cc
  task automatic t_reset;
    trg;
    @(posedge clk);
    rst <= 1'h1;
    tick(2);
    chk("reset hold", {armed, busy, play, ccf}, 4'h0);
    @(posedge clk);
    rst <= 1'h0;
    tick(2);
    chk("reset out", {armed, busy, txv, loading}, 4'h0);
  endtask : t_reset
  task automatic t_load(input logic [6:0] k);
    u_far.send(8'hF0);
    for (int i = 0; i < 2224; i++) begin
      u_far.send({1'h0, 7'(i) ^ k});
      if (i == 100) begin
        u_far.send(8'hFA);
        chk("play in load", play, 1'h0);
      end
      if (i == 200) begin
        u_far.send(8'hF8);
        chk("pass in load", {pv, pd}, 9'h1F8);
      end
    end
    chk("loading", loading, 1'h1);
    u_far.send(8'hF7);
    tick(1);
    chk("load end", loading, 1'h0);
  endtask : t_load
  task automatic t_dump(input logic [1:0] t, input int base, input int n, input logic [6:0] k);
    int w;
    w = 0;
    @(posedge clk);
    dtype <= t;
    slow <= 1'h1;
    u_far.got.delete();
    trg;
    trg;
    chk("busy", busy, 1'h1);
    while ((busy || txv) && w < 20000) begin
      tick(1);
      w++;
    end
    chk("drain", w < 20000, 1'h1);
    tick(4);
    chk("count", 12'(u_far.got.size()), 12'(n));
    for (int j = 0; j < n; j++)
      chk("byte", u_far.got[j], 12'(7'(base + j) ^ k));
    slow <= 1'h0;
  endtask : t_dump
  task automatic wrap_up;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (90000) @(posedge clk);
    fails++;
    wrap_up;
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    for (int s = 0; s < 4; s++)
      t_setting(2'(s));
    t_cc;
    t_cancel;
    t_reset;
    t_load(7'h00);
    t_dump(2'h0, 0, 2048, 7'h00);
    t_dump(2'h1, 2048, 160, 7'h00);
    t_load(7'h2A);
    t_dump(2'h2, 0, 2224, 7'h2A);
    wrap_up;
  end
endmodule : testbench
